// file: ssfm_pkg.sv
package ssfm_pkg;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [7:0] SSFM_OFF_TRANSMIT_HOLDING   = 8'h00;
  localparam logic [7:0] SSFM_OFF_RECEIVE_HOLDING    = 8'h04;
  localparam logic [7:0] SSFM_OFF_BIT_RATE_DIVIDER   = 8'h08;
  localparam logic [7:0] SSFM_OFF_SERIAL_MODE_SELECT = 8'h0C;
  localparam logic [7:0] SSFM_OFF_TRANSFER_CONTROL_A = 8'h10;
  localparam logic [7:0] SSFM_OFF_TRANSFER_CONTROL_B = 8'h14;
  localparam logic [7:0] SSFM_OFF_SPECIAL_MODE_BASE  = 8'h18;
  localparam logic [7:0] SSFM_OFF_TX_INTERRUPT_CTRL  = 8'h28;
  localparam logic [7:0] SSFM_OFF_PORT_LEVEL         = 8'h2C;
  localparam int         SSFM_NUM_SPECIAL_MODE       = 4;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int SSFM_MR_MODE_LSB     = 0;
  localparam int SSFM_MR_CLK_SRC      = 3;
  localparam int SSFM_CA_CNT_SRC_LSB  = 0;
  localparam int SSFM_CA_FLOW_SEL     = 2;
  localparam int SSFM_CA_SHIFT_EMPTY  = 3;
  localparam int SSFM_CA_FLOW_DIS     = 4;
  localparam int SSFM_CA_OUT_TYPE     = 5;
  localparam int SSFM_CA_CLK_POL      = 6;
  localparam int SSFM_CA_BIT_ORDER    = 7;
  localparam int SSFM_CB_TX_EN        = 0;
  localparam int SSFM_CB_TX_EMPTY     = 1;
  localparam int SSFM_CB_RX_EN        = 2;
  localparam int SSFM_CB_RX_DONE      = 3;
  localparam int SSFM_CB_IRQ_CAUSE    = 4;
  localparam int SSFM_CB_CONT_RX      = 5;
  localparam int SSFM_CB_INVERT       = 6;
  localparam int SSFM_RH_OVERRUN      = 12;
  localparam int SSFM_TIC_LEVEL_LSB   = 0;
  localparam int SSFM_TIC_REQUEST     = 3;
  localparam int SSFM_PL_SELECT       = 0;
  localparam int SSFM_PL_CLOCK        = 1;
  localparam int SSFM_PL_DATA         = 2;

  // ****************************************************************
  // Values after reset and codes
  // ****************************************************************
  localparam logic [2:0] SSFM_MODE_SYNC          = 3'h1;
  localparam logic [7:0] SSFM_RST_SPECIAL_MODE   = 8'h00;
  localparam logic [7:0] SSFM_RST_CONTROL_A      = 8'h08;
  localparam logic [7:0] SSFM_RST_CONTROL_B      = 8'h02;
  localparam logic [7:0] SSFM_RST_PORT_LEVEL     = 8'h07;
  localparam logic [7:0] SSFM_DUMMY_TX_BYTE      = 8'hFF;

  // Prescaler divide ratios per count source code
  localparam logic [4:0] SSFM_PRESC_MASK_0 = 5'h00;
  localparam logic [4:0] SSFM_PRESC_MASK_1 = 5'h07;
  localparam logic [4:0] SSFM_PRESC_MASK_2 = 5'h1F;
  localparam logic [4:0] SSFM_PRESC_MASK_3 = 5'h01;

  // Index of the last of the 16 half periods in one byte
  localparam logic [3:0] SSFM_LAST_HALF = 4'hF;

  typedef enum logic {SSFM_IDLE, SSFM_SHIFT} ssfm_state_t;

endpackage

// file: ssfm_top.sv
// Decided for this implementation: the address map and the Wishbone slave port.
`timescale 1ns/100ps

// Overview of operation
// R1: Mode field value 001b selects clock-synchronous serial operation.
// R2: Clock source bit 0 makes the transfer clock from the divider.
// R3: Count source bits pick the prescaled clock; eight divider bits set speed.
// R4: Polarity 0: data changes on falling clock edge, sampled on rising.
// R5: Bit order bit 1 shifts bytes most significant bit first.
// R6: Flow-control disable 1 turns off CTS/RTS; flow select then ignored.
// R7: Output type 0 drives data and clock push-pull, else open-drain.
// R8: Transmission only while transmit enable is 1; reset leaves it 0. Continuous receive still shifts dummy bytes out while it is 0.
// R9: Reception only while receive enable is 1; reset leaves it 0.
// R10: Read-only flag shows the transmit buffer can take another byte.
// R11: Read-only flag shows the last byte fully shifted out.
// R12: Read-only flag shows a received byte waits in the receive buffer.
// R13: Received byte in bits 7..0, plus overrun flag for a lost byte.
// R14: Cause select 0 raises transmit request when transmit buffer empties.
// R15: Continuous receive 0: reception only alongside a transmission.
// R16: Inversion bit 0 passes data bits without inverting them.
// R17: Priority level 000b disables the transmit interrupt.
// R18: Request bit set on transmit request even if disabled; write 0 clears.
// R19: Software raises select, then clock, enables channel, lowers select.
// R20: Software raises select, disables channel, returns pins high.
// R21: Software waits between select edges and the clock edges.
// R22: The four special mode registers reset to 00.
// R23: Each transmit byte gives eight clocks and captures eight received bits.
module ssfm_top
  import ssfm_pkg::*;
#(
  parameter int DATA_BITS = 8
)
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             flash_select,
  output logic             sclk_out,
  output logic             sclk_oe,
  input  wire logic        sclk_in,
  output logic             sdata_out,
  output logic             sdata_oe,
  input  wire logic        sdata_in,
  input  wire logic        clear_to_send_n,
  output logic             request_to_send_n,
  output logic             tx_irq
);

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [7:0]           bit_rate_divider;
  logic [7:0]           serial_mode_select;
  logic [7:0]           transfer_control_a;
  logic [7:0]           transfer_control_b;
  logic [7:0]           tx_interrupt_control;
  logic [7:0]           port_level;
  logic [7:0]           special_mode [SSFM_NUM_SPECIAL_MODE];
  logic [DATA_BITS-1:0] transmit_holding;
  logic [DATA_BITS-1:0] rx_data;
  logic                 tx_buf_empty;
  logic                 rx_done;
  logic                 overrun;
  logic                 irq_request;

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic [1:0] sdata_sync;
  logic [1:0] sclk_sync;
  logic [1:0] cts_sync;
  logic       sclk_prev;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sdata_sync <= 2'h3;
      sclk_sync  <= 2'h3;
      cts_sync   <= 2'h3;
      sclk_prev  <= 1'b1;
    end
    else
    begin
      sdata_sync <= {sdata_sync[0], sdata_in};
      sclk_sync  <= {sclk_sync[0], sclk_in};
      cts_sync   <= {cts_sync[0], clear_to_send_n};
      sclk_prev  <= sclk_sync[1];
    end
  end

  // ****************************************************************
  // Control decode
  // ****************************************************************
  logic       sync_mode;
  logic       clk_external;
  logic [1:0] cnt_src;
  logic       flow_dis;
  logic       flow_sel;
  logic       open_drain;
  logic       clk_pol;
  logic       msb_first;
  logic       tx_en;
  logic       rx_en;
  logic       irq_cause;
  logic       cont_rx;
  logic       invert;
  logic       cts_ok;

  assign sync_mode    = serial_mode_select[SSFM_MR_MODE_LSB +: 3] == SSFM_MODE_SYNC; // see R1
  assign clk_external = serial_mode_select[SSFM_MR_CLK_SRC];
  assign cnt_src      = transfer_control_a[SSFM_CA_CNT_SRC_LSB +: 2];
  assign flow_dis     = transfer_control_a[SSFM_CA_FLOW_DIS];
  assign flow_sel     = transfer_control_a[SSFM_CA_FLOW_SEL];
  assign open_drain   = transfer_control_a[SSFM_CA_OUT_TYPE];
  assign clk_pol      = transfer_control_a[SSFM_CA_CLK_POL];
  assign msb_first    = transfer_control_a[SSFM_CA_BIT_ORDER];
  assign tx_en        = transfer_control_b[SSFM_CB_TX_EN];
  assign rx_en        = transfer_control_b[SSFM_CB_RX_EN];
  assign irq_cause    = transfer_control_b[SSFM_CB_IRQ_CAUSE];
  assign cont_rx      = transfer_control_b[SSFM_CB_CONT_RX];
  assign invert       = transfer_control_b[SSFM_CB_INVERT];
  // CTS gating only when flow control on and selected as CTS
  assign cts_ok       = flow_dis || flow_sel || !cts_sync[1]; // see R6

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  logic bus_req;
  logic bus_wr;
  logic bus_rd;

  assign bus_req = wb_cyc_i && wb_stb_i;
  assign bus_wr  = bus_req && wb_ack_o && wb_we_i && wb_sel_i[0];
  assign bus_rd  = bus_req && wb_ack_o && !wb_we_i;

  // ****************************************************************
  // Bit-rate generation
  // ****************************************************************
  ssfm_state_t state;
  logic [4:0]  presc_cnt;
  logic [4:0]  presc_mask;
  logic        presc_tick;
  logic [7:0]  brg_cnt;
  logic        half_tick;

  always_comb
  begin
    if (cnt_src == 2'h0)
      presc_mask = SSFM_PRESC_MASK_0;
    else if (cnt_src == 2'h1)
      presc_mask = SSFM_PRESC_MASK_1;
    else if (cnt_src == 2'h2)
      presc_mask = SSFM_PRESC_MASK_2;
    else
      presc_mask = SSFM_PRESC_MASK_3;
  end

  assign presc_tick = (presc_cnt & presc_mask) == presc_mask; // see R3

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      presc_cnt <= 5'h00;
    else
      presc_cnt <= presc_cnt + 5'h01;
  end

  // Divider reloads while idle so each byte starts a full half period
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      brg_cnt <= 8'h00;
    else if (state == SSFM_IDLE)
      brg_cnt <= bit_rate_divider;
    else if (presc_tick)
      brg_cnt <= (brg_cnt == 8'h00) ? bit_rate_divider : brg_cnt - 8'h01; // see R3
  end

  // External clock edges stand in for divider ticks
  assign half_tick = clk_external ? (sclk_sync[1] != sclk_prev)
                                  : (presc_tick && brg_cnt == 8'h00); // see R2

  // ****************************************************************
  // Shift engine
  // ****************************************************************
  logic [DATA_BITS-1:0] tx_shift;
  logic [DATA_BITS-1:0] rx_shift;
  logic [DATA_BITS-1:0] rx_next;
  logic [3:0]           half_idx;
  logic                 sclk_level;
  logic                 data_level;
  logic                 rx_bit;
  logic                 start_tx;
  logic                 start_rx;
  logic                 byte_done;
  logic                 rx_active;

  assign rx_bit    = sdata_sync[1] ^ invert; // see R16
  assign rx_next   = msb_first ? {rx_shift[DATA_BITS-2:0], rx_bit}
                               : {rx_bit, rx_shift[DATA_BITS-1:1]}; // see R5
  assign start_tx  = sync_mode && tx_en && !tx_buf_empty && cts_ok; // see R8
  // Continuous receive clocks a dummy byte once the last one is read
  assign start_rx  = sync_mode && cont_rx && rx_en && !rx_done; // see R15
  assign byte_done = state == SSFM_SHIFT && half_tick && half_idx == SSFM_LAST_HALF;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state      <= SSFM_IDLE;
      half_idx   <= 4'h0;
      tx_shift   <= '0;
      rx_shift   <= '0;
      rx_active  <= 1'b0;
      sclk_level <= 1'b1;
      data_level <= 1'b1;
    end
    else
    begin
      case (state)
        SSFM_IDLE:
        begin
          sclk_level <= !clk_pol; // see R4
          half_idx   <= 4'h0;
          if (start_tx || start_rx)
          begin
            state     <= SSFM_SHIFT;
            tx_shift  <= start_tx ? transmit_holding : DATA_BITS'(SSFM_DUMMY_TX_BYTE); // see R23
            rx_active <= rx_en; // see R9
          end
        end
        SSFM_SHIFT:
        begin
          if (!sync_mode)
            state <= SSFM_IDLE;
          else if (half_tick)
          begin
            half_idx <= half_idx + 4'h1;
            if (!half_idx[0])
            begin
              // Leading edge: falling for polarity 0, drives next bit
              sclk_level <= clk_pol; // see R4
              data_level <= (msb_first ? tx_shift[DATA_BITS-1] : tx_shift[0]) ^ invert; // see R5
              tx_shift   <= msb_first ? {tx_shift[DATA_BITS-2:0], 1'b0}
                                      : {1'b0, tx_shift[DATA_BITS-1:1]};
            end
            else
            begin
              // Trailing edge samples receive data
              sclk_level <= !clk_pol; // see R4
              rx_shift   <= rx_next; // see R23
              if (half_idx == SSFM_LAST_HALF)
                state <= SSFM_IDLE;
            end
          end
        end
        default:
          state <= SSFM_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Transmit buffer and request bit
  // ****************************************************************
  logic tx_request;

  assign tx_request = irq_cause ? byte_done : (state == SSFM_IDLE && start_tx); // see R14

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tx_buf_empty     <= 1'b1;
      transmit_holding <= '0;
    end
    else if (bus_wr && wb_adr_i == SSFM_OFF_TRANSMIT_HOLDING)
    begin
      transmit_holding <= wb_dat_i[DATA_BITS-1:0];
      tx_buf_empty     <= 1'b0; // see R10
    end
    else if (state == SSFM_IDLE && start_tx)
      tx_buf_empty <= 1'b1; // see R10
  end

  // Set beats a same-cycle software clear
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      irq_request <= 1'b0;
    else if (tx_request)
      irq_request <= 1'b1; // see R18
    else if (bus_wr && wb_adr_i == SSFM_OFF_TX_INTERRUPT_CTRL
             && !wb_dat_i[SSFM_TIC_REQUEST])
      irq_request <= 1'b0; // see R18
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      tx_irq <= 1'b0;
    else
      tx_irq <= irq_request && tx_interrupt_control[SSFM_TIC_LEVEL_LSB +: 3] != 3'h0; // see R17
  end

  // ****************************************************************
  // Receive buffer
  // ****************************************************************
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rx_data <= '0;
      rx_done <= 1'b0;
      overrun <= 1'b0;
    end
    else
    begin
      if (byte_done && rx_active)
      begin
        rx_data <= rx_next; // see R13
        rx_done <= 1'b1; // see R12
        if (rx_done && !(bus_rd && wb_adr_i == SSFM_OFF_RECEIVE_HOLDING))
          overrun <= 1'b1; // see R13
      end
      else if (bus_rd && wb_adr_i == SSFM_OFF_RECEIVE_HOLDING)
        rx_done <= 1'b0;
      if (!rx_en)
        overrun <= 1'b0;
    end
  end

  // ****************************************************************
  // Software registers
  // ****************************************************************
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      bit_rate_divider     <= 8'h00;
      serial_mode_select   <= 8'h00;
      transfer_control_a   <= SSFM_RST_CONTROL_A;
      transfer_control_b   <= SSFM_RST_CONTROL_B; // see R8
      tx_interrupt_control <= 8'h00;
      port_level           <= SSFM_RST_PORT_LEVEL;
    end
    else if (bus_wr)
    begin
      if (wb_adr_i == SSFM_OFF_BIT_RATE_DIVIDER)
        bit_rate_divider <= wb_dat_i[7:0];
      else if (wb_adr_i == SSFM_OFF_SERIAL_MODE_SELECT)
        serial_mode_select <= wb_dat_i[7:0];
      else if (wb_adr_i == SSFM_OFF_TRANSFER_CONTROL_A)
        transfer_control_a <= wb_dat_i[7:0];
      else if (wb_adr_i == SSFM_OFF_TRANSFER_CONTROL_B)
        transfer_control_b <= wb_dat_i[7:0]; // see R9
      else if (wb_adr_i == SSFM_OFF_TX_INTERRUPT_CTRL)
        tx_interrupt_control <= wb_dat_i[7:0];
      else if (wb_adr_i == SSFM_OFF_PORT_LEVEL)
        port_level <= wb_dat_i[7:0];
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < SSFM_NUM_SPECIAL_MODE; gi++)
    begin : g_special
      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
          special_mode[gi] <= SSFM_RST_SPECIAL_MODE; // see R22
        else if (bus_wr && wb_adr_i == SSFM_OFF_SPECIAL_MODE_BASE + 8'(4 * gi))
          special_mode[gi] <= wb_dat_i[7:0];
      end
    end
  endgenerate

  // ****************************************************************
  // Bus answer
  // ****************************************************************
  logic [31:0] rd_data;

  always_comb
  begin
    rd_data = 32'h0000_0000;
    if (wb_adr_i == SSFM_OFF_RECEIVE_HOLDING)
    begin
      rd_data[DATA_BITS-1:0]  = rx_data;
      rd_data[SSFM_RH_OVERRUN] = overrun;
    end
    else if (wb_adr_i == SSFM_OFF_BIT_RATE_DIVIDER)
      rd_data[7:0] = bit_rate_divider;
    else if (wb_adr_i == SSFM_OFF_SERIAL_MODE_SELECT)
      rd_data[7:0] = serial_mode_select;
    else if (wb_adr_i == SSFM_OFF_TRANSFER_CONTROL_A)
    begin
      rd_data[7:0] = transfer_control_a;
      rd_data[SSFM_CA_SHIFT_EMPTY] = state == SSFM_IDLE; // see R11
    end
    else if (wb_adr_i == SSFM_OFF_TRANSFER_CONTROL_B)
    begin
      rd_data[7:0] = transfer_control_b;
      rd_data[SSFM_CB_TX_EMPTY] = tx_buf_empty; // see R10
      rd_data[SSFM_CB_RX_DONE]  = rx_done; // see R12
    end
    else if (wb_adr_i == SSFM_OFF_TX_INTERRUPT_CTRL)
    begin
      rd_data[7:0] = tx_interrupt_control;
      rd_data[SSFM_TIC_REQUEST] = irq_request; // see R18
    end
    else if (wb_adr_i == SSFM_OFF_PORT_LEVEL)
      rd_data[7:0] = port_level;
    else
    begin
      for (int i = 0; i < SSFM_NUM_SPECIAL_MODE; i++)
        if (wb_adr_i == SSFM_OFF_SPECIAL_MODE_BASE + 8'(4 * i))
          rd_data[7:0] = special_mode[i];
    end
  end

  // One wait state; unmapped reads answer zero, writes are dropped
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= bus_req && !wb_ack_o;
      wb_dat_o <= (bus_req && !wb_ack_o) ? rd_data : 32'h0000_0000;
    end
  end

  // ****************************************************************
  // Pin drivers
  // ****************************************************************
  logic pin_clk;
  logic pin_data;
  logic pin_od;

  // Outside serial mode the pins fall back to the port levels
  assign pin_clk  = sync_mode ? sclk_level : port_level[SSFM_PL_CLOCK];
  assign pin_data = sync_mode ? data_level : port_level[SSFM_PL_DATA];
  assign pin_od   = sync_mode && open_drain;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      flash_select      <= 1'b1;
      sclk_out          <= 1'b1;
      sclk_oe           <= 1'b1;
      sdata_out         <= 1'b1;
      sdata_oe          <= 1'b1;
      request_to_send_n <= 1'b1;
    end
    else
    begin
      flash_select      <= port_level[SSFM_PL_SELECT];
      sclk_out          <= pin_od ? 1'b0 : pin_clk; // see R7
      sclk_oe           <= pin_od ? !pin_clk : !(sync_mode && clk_external); // see R7
      sdata_out         <= pin_od ? 1'b0 : pin_data; // see R7
      sdata_oe          <= pin_od ? !pin_data : 1'b1; // see R7
      request_to_send_n <= (flow_dis || !flow_sel) ? 1'b1 : !(rx_en && !rx_done); // see R6
    end
  end

endmodule

// file: ssfm_chk_sva.sv
`timescale 1ns/100ps
// ****************************************************************
// Port checks
// ****************************************************************
module ssfm_chk
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        flash_select,
  input wire logic        sclk_out,
  input wire logic        sdata_out,
  input wire logic        tx_irq
);
  logic [3:0] rises;
  logic       sclk_d;

  // Clock pulses seen while the flash is selected
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rises <= 4'h0;
    else if (flash_select)
      rises <= 4'h0;
    else if (sclk_out && !sclk_d)
      rises <= rises + 4'h1;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      sclk_d <= 1'b1;
    else
      sclk_d <= sclk_out;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack not one cycle after request");
  a_ack_cause: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  a_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  a_read_width: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:13] == 19'h0 && wb_dat_o[11:8] == 4'h0)
    else $error("read data outside register width");
  a_reset_pins: assert property ($past(rst) |-> flash_select && sclk_out && sdata_out && !tx_irq)
    else $error("pins not idle after reset");
  a_byte_clocks: assert property ($rose(flash_select) |-> rises[2:0] == 3'h0)
    else $error("partial byte of clock pulses");
  a_clock_idle: assert property ($rose(flash_select) |-> sclk_out)
    else $error("clock not idle high at deselect");
endmodule

bind ssfm_top ssfm_chk chk_u (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .flash_select(flash_select),
  .sclk_out(sclk_out), .sdata_out(sdata_out), .tx_irq(tx_irq));

// file: ssfm_flash_model.sv
`timescale 1ns/100ps
// ****************************************************************
// Serial flash stand-in
// ****************************************************************
module ssfm_flash_model
#(
  parameter logic [7:0] REPLY = 8'h3C
)
(
  input  wire logic       select,
  input  wire logic       sclk,
  input  wire logic       mosi,
  output logic            miso,
  output logic [7:0]      got
);
  logic [7:0] tx = REPLY;
  initial miso = 1'b0;
  // Output moves on falling clock, MSB first; reply repeats every byte
  always @(negedge sclk or posedge select or negedge select)
  begin
    if (select)
      miso <= ~miso; // Released line shows no stale bit
    else if (sclk)
      tx <= REPLY;
    else
    begin
      miso <= tx[7];
      tx   <= {tx[6:0], tx[7]};
    end
  end
  always @(posedge sclk) if (!select) got <= {got[6:0], mosi};
endmodule

// file: tb_top.sv
`timescale 1ns/100ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin fails++; $display("[ERR] %s exp %0h got %0h", n, e, g); end end
// ****************************************************************
// Bench
// ****************************************************************
module tb_top;
  import ssfm_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat_i = 32'h0, wb_dat_o, rd;
  logic        wb_ack_o, flash_select, sclk_out, sclk_oe, sdata_out, sdata_oe, tx_irq, miso, rts_n;
  logic        sclk_p = 1'b1;
  logic [7:0]  got;
  int          fails = 0, compares = 0, rises = 0;
  // Pull-ups on the shared pins
  wire sclk_w  = sclk_oe ? sclk_out : 1'b1;
  wire sdata_w = sdata_oe ? sdata_out : 1'b1;

  always #4 clk = ~clk;
  always @(posedge clk)
  begin
    sclk_p <= sclk_w;
    if (sclk_w && !sclk_p) rises++;
  end

  ssfm_top dut_u (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .flash_select(flash_select), .sclk_out(sclk_out), .sclk_oe(sclk_oe), .sclk_in(sclk_w),
    .sdata_out(sdata_out), .sdata_oe(sdata_oe), .sdata_in(miso), .clear_to_send_n(1'b1),
    .request_to_send_n(rts_n), .tx_irq(tx_irq));
  ssfm_flash_model flash_u (.select(flash_select), .sclk(sclk_w), .mosi(sdata_w), .miso(miso),
    .got(got));

  task test_done;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int i;
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat_i <= {24'h0, d};
    for (i = 0; i < 20 && wb_ack_o !== 1'b1; i++) @(posedge clk);
    if (i == 20) begin fails++; test_done; end
    rd = wb_dat_o;
    cyc <= 1'b0; stb <= 1'b0;
  endtask

  task wait_rises(input int n);
    int i;
    for (i = 0; i < 3000 && rises < n; i++) @(posedge clk);
    if (rises < n) begin fails++; test_done; end
    repeat (40) @(posedge clk);
  endtask

  task t_reset;
    int k;
    for (k = 0; k < SSFM_NUM_SPECIAL_MODE; k++)
    begin
      wb(1'b0, SSFM_OFF_SPECIAL_MODE_BASE + 8'(4 * k), 8'h00);
      `CHK("special mode", 32'h0, rd)
    end
    wb(1'b0, SSFM_OFF_TRANSFER_CONTROL_A, 8'h00);
    `CHK("control a", 32'h08, rd)
    wb(1'b0, SSFM_OFF_TRANSFER_CONTROL_B, 8'h00);
    `CHK("control b", 32'h02, rd)
    wb(1'b0, 8'h3C, 8'h00);
    `CHK("unmapped", 32'h0, rd)
    $display("test reset done");
  endtask

  task t_tx_off;
    wb(1'b1, SSFM_OFF_SERIAL_MODE_SELECT, 8'h01);
    wb(1'b1, SSFM_OFF_TRANSFER_CONTROL_A, 8'h90);
    wb(1'b1, SSFM_OFF_BIT_RATE_DIVIDER, 8'h07);
    wb(1'b1, SSFM_OFF_PORT_LEVEL, 8'h06);
    wb(1'b1, SSFM_OFF_TRANSMIT_HOLDING, 8'h11);
    repeat (300) @(posedge clk);
    `CHK("clocks while disabled", 0, rises)
    $display("test tx_off done");
  endtask

  task t_xfer;
    wb(1'b1, SSFM_OFF_TRANSFER_CONTROL_B, 8'h05);
    wait_rises(8);
    `CHK("clock pulses", 8, rises)
    `CHK("flash got", 8'h11, got)
    `CHK("rts off", 1'b1, rts_n)
    `CHK("push-pull", 2'h3, {sclk_oe, sdata_oe})
    wb(1'b0, SSFM_OFF_TRANSFER_CONTROL_A, 8'h00);
    `CHK("shifter empty", 1'b1, rd[SSFM_CA_SHIFT_EMPTY])
    wb(1'b0, SSFM_OFF_TRANSFER_CONTROL_B, 8'h00);
    `CHK("rx and buffer flags", 4'hF, rd[3:0])
    wb(1'b0, SSFM_OFF_RECEIVE_HOLDING, 8'h00);
    `CHK("received", 32'h3C, rd)
    wb(1'b0, SSFM_OFF_TRANSFER_CONTROL_B, 8'h00);
    `CHK("rx flag cleared", 1'b0, rd[SSFM_CB_RX_DONE])
    $display("test xfer done");
  endtask

  task t_irq;
    wb(1'b0, SSFM_OFF_TX_INTERRUPT_CTRL, 8'h00);
    `CHK("request bit", 32'h08, rd)
    `CHK("irq at level 0", 1'b0, tx_irq)
    wb(1'b1, SSFM_OFF_TX_INTERRUPT_CTRL, 8'h0F);
    repeat (3) @(posedge clk);
    `CHK("irq at level 7", 1'b1, tx_irq)
    wb(1'b1, SSFM_OFF_TX_INTERRUPT_CTRL, 8'h00);
    repeat (3) @(posedge clk);
    wb(1'b0, SSFM_OFF_TX_INTERRUPT_CTRL, 8'h00);
    `CHK("request cleared", 32'h0, rd)
    `CHK("irq cleared", 1'b0, tx_irq)
    $display("test irq done");
  endtask

  task t_overrun;
    wb(1'b1, SSFM_OFF_TRANSMIT_HOLDING, 8'hA5);
    wait_rises(16);
    wb(1'b1, SSFM_OFF_TRANSMIT_HOLDING, 8'h5A);
    wait_rises(24);
    `CHK("flash got", 8'h5A, got)
    wb(1'b0, SSFM_OFF_RECEIVE_HOLDING, 8'h00);
    `CHK("overrun", 32'h103C, rd)
    repeat (300) @(posedge clk);
    `CHK("no self-started rx", 24, rises)
    wb(1'b1, SSFM_OFF_PORT_LEVEL, 8'h07);
    wb(1'b1, SSFM_OFF_TRANSFER_CONTROL_B, 8'h00);
    $display("test overrun done");
  endtask

  task t_order;
    wb(1'b1, SSFM_OFF_SERIAL_MODE_SELECT, 8'h01);
    wb(1'b1, SSFM_OFF_TRANSFER_CONTROL_A, 8'h10);
    wb(1'b1, SSFM_OFF_PORT_LEVEL, 8'h06);
    wb(1'b1, SSFM_OFF_TRANSFER_CONTROL_B, 8'h45);
    wb(1'b1, SSFM_OFF_TRANSMIT_HOLDING, 8'h01);
    wait_rises(32);
    `CHK("lsb first sent", 8'h7F, got)
    wb(1'b0, SSFM_OFF_RECEIVE_HOLDING, 8'h00);
    `CHK("lsb first received", 32'hC3, rd)
    wb(1'b1, SSFM_OFF_PORT_LEVEL, 8'h07);
    wb(1'b1, SSFM_OFF_TRANSFER_CONTROL_B, 8'h00);
    wb(1'b1, SSFM_OFF_SERIAL_MODE_SELECT, 8'h00);
    repeat (2) @(posedge clk);
    `CHK("pins to port", 3'h7, {flash_select, sclk_out, sdata_out})
    $display("test order done");
  endtask

  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_tx_off;
    t_xfer;
    t_irq;
    t_overrun;
    t_order;
    test_done;
  end
endmodule
